// File: rtl/spc_pkg.sv
package spc_pkg;
    localparam int DATA_W = 24;
    localparam int WORD_W = 27;
    localparam int FIFO_DEPTH = 4;
    localparam int FRAME_W = 30;
    localparam int AXI_AW = 8;
    localparam logic [4:0] FRAME_LAST = 5'd29;
    localparam logic [1:0] FILT_LAST = 2'd2;
    localparam logic [4:0] BAL_HALF = 5'd13;

    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam logic [AXI_AW-1:0] ADDR_CTRL = 8'h00;
    localparam logic [AXI_AW-1:0] ADDR_STATUS = 8'h04;
    localparam logic [AXI_AW-1:0] ADDR_FRAMES = 8'h08;
    localparam int CTRL_EDGE_OVR = 0;
    localparam int CTRL_EDGE_VAL = 1;
    localparam int CTRL_CFG_OVR = 2;
    localparam int CTRL_CFG_LO = 3;
    localparam int CTRL_DRV_OVR = 5;
    localparam int CTRL_DRV_VAL = 6;
    localparam logic [6:0] CTRL_RESET = 7'h00;
    localparam int STAT_DROP = 5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // --------------------------------------------------------------
    // Modes and seeds
    // --------------------------------------------------------------
    localparam logic [1:0] CFG_FILT_ON = 2'h1;
    localparam logic [1:0] CFG_LEGACY_B = 2'h3;
    localparam logic [15:0] SCR_SEED = 16'hace1;
    localparam logic [15:0] PRBS_SEED = 16'h5a5a;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SEND = 2'h1
    } spc_state_t;
endpackage

// File: rtl/spc_stream_if.sv
`timescale 1ns/10ps
interface spc_stream_if #(parameter int WIDTH = 27);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// File: rtl/spc_fifo.sv
`timescale 1ns/10ps
module spc_fifo #(
    parameter int WIDTH = 27,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Streams
    spc_stream_if.snk fill,
    spc_stream_if.src drain
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW:0] count;

    wire push = fill.valid & fill.ready;
    wire pop = drain.valid & drain.ready;

    assign fill.ready = (count != (PW+1)'(DEPTH));
    assign drain.valid = (count != '0);
    assign drain.data = mem[rdPtr];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr] <= fill.data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= rdPtr + 1'b1;
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule // spc_fifo

// File: rtl/spc_top.sv
`timescale 1ns/10ps
module spc_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Parallel pixel input
    input wire logic pixelClockIn,
    input wire logic [23:0] pixelWordIn,
    input wire logic dataEnableIn,
    input wire logic hsyncIn,
    input wire logic vsyncIn,
    output logic pixelReady,
    // Configuration pins
    input wire logic strobeEdgeSelect,
    input wire logic [1:0] modeSelect,
    input wire logic driveLevelSelect,
    input wire logic powerDown_n,
    input wire logic selftestEnable,
    // Serial link and analog controls
    output logic serialOutP,
    output logic serialOutN,
    output logic pllEnable,
    output logic driveLevel,
    output logic legacyMode,
    output logic filterActive,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic [15:0] lfsrNext(input logic [15:0] s);
        lfsrNext = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [4:0] onesOf(input logic [26:0] w);
        logic [4:0] n;
        n = '0;
        for (int k = 0; k < spc_pkg::WORD_W; k++) begin
            n = n + 5'(w[k]);
        end
        onesOf = n;
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [6:0] ctrlReg;
    logic dropSticky;
    logic [31:0] frameCount;
    logic pixClkPrev;
    logic [23:0] capWord;
    logic capVsync;
    logic capValid;
    logic [1:0] rawCtl;
    wire [1:0] filtCtl;
    spc_pkg::spc_state_t state;
    logic [29:0] shiftReg;
    logic [4:0] bitCnt;
    logic [15:0] scrLfsr;
    logic [15:0] prbsLfsr;
    logic dispHigh;
    logic [7:0] awAddr;
    logic awHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic wHeld;

    spc_stream_if #(.WIDTH(spc_pkg::WORD_W)) fillIf ();
    spc_stream_if #(.WIDTH(spc_pkg::WORD_W)) drainIf ();

    // ------------------------------------------------------------------
    // Effective settings
    // ------------------------------------------------------------------
    // Power-down doubles as a reset of everything but the bus handshake and the pin-level output registers
    wire pdReset = ~rst_n | ~powerDown_n;
    wire linkUp = powerDown_n;
    wire edgeRise = ctrlReg[spc_pkg::CTRL_EDGE_OVR] ?
        ctrlReg[spc_pkg::CTRL_EDGE_VAL] : strobeEdgeSelect;
    wire [1:0] cfgEff = ctrlReg[spc_pkg::CTRL_CFG_OVR] ?
        ctrlReg[spc_pkg::CTRL_CFG_LO +: 2] : modeSelect;
    wire driveEff = ctrlReg[spc_pkg::CTRL_DRV_OVR] ?
        ctrlReg[spc_pkg::CTRL_DRV_VAL] : driveLevelSelect;
    wire filtOn = (cfgEff == spc_pkg::CFG_FILT_ON);
    wire legacy = cfgEff[1];
    wire noBalance = (cfgEff == spc_pkg::CFG_LEGACY_B);
    wire bist = selftestEnable;

    // ------------------------------------------------------------------
    // Capture
    // ------------------------------------------------------------------
    // Pixel clock is oversampled, so it must stay well under mclk / 2
    wire pixRise = pixelClockIn & ~pixClkPrev;
    wire pixFall = ~pixelClockIn & pixClkPrev;
    wire capture = linkUp & (edgeRise ? pixRise : pixFall);
    wire dropNow = capture & capValid & ~fillIf.ready;

    always_ff @(posedge mclk) begin
        if (pdReset) begin
            pixClkPrev <= 1'b0;
            capWord <= '0;
            capVsync <= 1'b0;
            capValid <= 1'b0;
        end else begin
            pixClkPrev <= pixelClockIn;
            if (capture) begin
                capWord <= pixelWordIn;
                capVsync <= vsyncIn;
                capValid <= 1'b1;
            end else if (fillIf.ready) begin
                capValid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control signal filter
    // ------------------------------------------------------------------
    assign rawCtl = {hsyncIn, dataEnableIn};

    generate
        for (genvar i = 0; i < 2; i++) begin : g_filt
            logic [1:0] runLen;
            logic held;
            wire differs = (rawCtl[i] != held);
            assign filtCtl[i] = held;
            always_ff @(posedge mclk) begin
                if (pdReset) begin
                    held <= 1'b0;
                    runLen <= '0;
                end else if (capture) begin
                    if (!filtOn || !differs) begin
                        held <= rawCtl[i];
                        runLen <= '0;
                    end else if (runLen == spc_pkg::FILT_LAST) begin
                        held <= rawCtl[i];
                        runLen <= '0;
                    end else begin
                        runLen <= runLen + 2'd1;
                    end
                end
            end
        end
    endgenerate

    assign fillIf.valid = capValid;
    assign fillIf.data = {capVsync, filtCtl, capWord};

    spc_fifo #(
        .WIDTH(spc_pkg::WORD_W),
        .DEPTH(spc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(mclk),
        .reset(pdReset),
        .fill(fillIf.snk),
        .drain(drainIf.src)
    );

    // ------------------------------------------------------------------
    // Frame build
    // ------------------------------------------------------------------
    // Frame, first bit out first: 1, 27 payload, invert flag, 0
    wire [26:0] payload = bist ?
        {prbsLfsr[10:0], prbsLfsr} : drainIf.data;
    wire [26:0] scrambled = legacy ?
        payload : payload ^ {scrLfsr[10:0], scrLfsr};
    wire heavy = (onesOf(scrambled) > spc_pkg::BAL_HALF);
    wire invert = ~noBalance & (heavy == dispHigh);
    wire [26:0] body = invert ? ~scrambled : scrambled;
    wire [29:0] frame = {1'b0, invert, body, 1'b1};
    wire idle = (state == spc_pkg::ST_IDLE);
    wire startFrame = idle & linkUp & (bist | drainIf.valid);

    assign drainIf.ready = idle & linkUp & ~bist;

    // ------------------------------------------------------------------
    // Serializer
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (pdReset) begin
            state <= spc_pkg::ST_IDLE;
            shiftReg <= '0;
            bitCnt <= '0;
            scrLfsr <= spc_pkg::SCR_SEED;
            prbsLfsr <= spc_pkg::PRBS_SEED;
            dispHigh <= 1'b0;
            frameCount <= '0;
            serialOutP <= 1'b1;
            serialOutN <= 1'b1;
        end else begin
            case (state)
                spc_pkg::ST_IDLE: begin
                    // Idle toggling keeps the far end's clock recovery fed
                    serialOutP <= ~serialOutP;
                    serialOutN <= serialOutP;
                    if (startFrame) begin
                        shiftReg <= frame;
                        bitCnt <= '0;
                        dispHigh <= heavy ^ invert;
                        scrLfsr <= lfsrNext(scrLfsr);
                        if (bist) begin
                            prbsLfsr <= lfsrNext(prbsLfsr);
                        end
                        state <= spc_pkg::ST_SEND;
                    end
                end
                spc_pkg::ST_SEND: begin
                    serialOutP <= shiftReg[0];
                    serialOutN <= ~shiftReg[0];
                    shiftReg <= {1'b0, shiftReg[29:1]};
                    bitCnt <= bitCnt + 5'd1;
                    if (bitCnt == spc_pkg::FRAME_LAST) begin
                        frameCount <= frameCount + 32'd1;
                        state <= spc_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= spc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pin-level outputs
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pllEnable <= 1'b0;
            driveLevel <= 1'b0;
            legacyMode <= 1'b0;
            filterActive <= 1'b0;
            pixelReady <= 1'b0;
        end else begin
            pllEnable <= powerDown_n;
            driveLevel <= driveEff;
            legacyMode <= legacy & linkUp;
            filterActive <= filtOn & linkUp;
            pixelReady <= linkUp & (fillIf.ready | ~capValid);
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    wire awTake = s_axi_awvalid & s_axi_awready;
    wire wTake = s_axi_wvalid & s_axi_wready;
    wire doWrite = awHeld & wHeld & ~s_axi_bvalid;
    wire wrCtrl = doWrite & (awAddr == spc_pkg::ADDR_CTRL);
    wire wrStat = doWrite & (awAddr == spc_pkg::ADDR_STATUS);
    wire wrHit = wrCtrl | wrStat | (awAddr == spc_pkg::ADDR_FRAMES);
    wire [31:0] statusWord = {26'h0, dropSticky, bist, cfgEff, edgeRise,
        linkUp};
    wire rdCtrl = (s_axi_araddr == spc_pkg::ADDR_CTRL);
    wire rdStat = (s_axi_araddr == spc_pkg::ADDR_STATUS);
    wire rdFrames = (s_axi_araddr == spc_pkg::ADDR_FRAMES);
    wire rdHit = rdCtrl | rdStat | rdFrames;
    wire [31:0] rdWord = rdCtrl ? {25'h0, ctrlReg} :
        rdStat ? statusWord : rdFrames ? frameCount : 32'h0;
    wire dropClr = wrStat & wStrb[0] & wData[spc_pkg::STAT_DROP];

    always_ff @(posedge mclk) begin
        if (pdReset) begin
            ctrlReg <= spc_pkg::CTRL_RESET;
            dropSticky <= 1'b0;
        end else begin
            if (wrCtrl && wStrb[0]) begin
                ctrlReg <= wData[6:0];
            end
            // A drop in the clearing cycle still leaves the flag set
            dropSticky <= dropNow | (dropSticky & ~dropClr);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= '0;
            wData <= '0;
            wStrb <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= spc_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= ~awHeld & ~awTake;
            s_axi_wready <= ~wHeld & ~wTake;
            if (awTake) begin
                awAddr <= s_axi_awaddr;
                awHeld <= 1'b1;
            end
            if (wTake) begin
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
                wHeld <= 1'b1;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrHit ? spc_pkg::RESP_OKAY :
                    spc_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                awHeld <= 1'b0;
                wHeld <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= spc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdWord;
            s_axi_rresp <= rdHit ? spc_pkg::RESP_OKAY :
                spc_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else begin
            s_axi_arready <= ~s_axi_rvalid;
        end
    end
endmodule // spc_top

// File: verif/spc_checker.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module spc_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Link and mode outputs
    input wire logic powerDown_n,
    input wire logic serialOutP,
    input wire logic serialOutN,
    input wire logic pllEnable,
    input wire logic legacyMode,
    input wire logic filterActive,
    // Register bus
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    AST_PD_LINE: assert property (
        !powerDown_n |=> serialOutP && serialOutN)
        else $error("serial lines not parked high in power-down");
    AST_PLL_FOLLOW: assert property (
        $past(rst_n) |-> pllEnable == $past(powerDown_n))
        else $error("pll enable does not follow power input");
    AST_PD_CTRL: assert property (
        !powerDown_n |=> !filterActive && !legacyMode)
        else $error("mode outputs not cleared by power-down");
    AST_MODE_EXCL: assert property (
        filterActive |-> !legacyMode)
        else $error("filter active in a legacy mode");
    AST_B_HOLD: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_B_BLOCK: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write taken while response pending");
    AST_R_LAT: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after address");
    AST_R_HOLD: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    AST_R_UNMAP: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h02
        |=> s_axi_rresp == spc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule // spc_checker

bind spc_top spc_checker u_chk (.*);

// File: verif/spc_pixel_source.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Pixel source model
// ------------------------------------------------------------
module spc_pixel_source (
    // Clock
    input wire logic mclk,
    // Pacing and content
    input wire logic run,
    input wire logic [7:0] halfPeriod,
    input wire logic [26:0] riseWord,
    input wire logic [26:0] fallWord,
    // Parallel pixel output
    output logic pixelClockIn,
    output logic [23:0] pixelWordIn,
    output logic dataEnableIn,
    output logic hsyncIn,
    output logic vsyncIn
);
    logic [8:0] phase;
    logic [26:0] drive;

    // Red 7:0, green 15:8, blue 23:16; controls de, hsync, vsync on top
    assign {vsyncIn, hsyncIn, dataEnableIn, pixelWordIn} = drive;

    initial begin
        phase = 9'h000;
        pixelClockIn = 1'b0;
        drive = 27'h0000000;
    end

    // Clock stands still between bursts; data moves mid-phase so that
    // either strobe edge sees a settled word
    always @(posedge mclk) begin
        if (!run) begin
            phase <= 9'h000;
            drive <= riseWord;
        end else begin
            if (phase == {halfPeriod, 1'b0} - 9'h001) phase <= 9'h000;
            else phase <= phase + 9'h001;
            if (phase == 9'h000) pixelClockIn <= 1'b1;
            if (phase == {1'b0, halfPeriod}) pixelClockIn <= 1'b0;
            if (phase == {2'b00, halfPeriod[7:1]}) drive <= fallWord;
            if (phase == {1'b0, halfPeriod} + {2'b00, halfPeriod[7:1]})
                drive <= riseWord;
        end
    end
endmodule // spc_pixel_source

// File: verif/serializer_parallel_input_capture_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
    begin \
        samples_checked++; \
        if ((got) !== (ex)) begin \
            n_fail++; \
            $display("CHECK FAILED %s exp=%0h got=%0h", nm, ex, got); \
        end \
    end

module serializer_parallel_input_capture_tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic mclk, rst_n, pixelClockIn, dataEnableIn, hsyncIn, vsyncIn;
    logic [23:0] pixelWordIn;
    logic pixelReady, strobeEdgeSelect, driveLevelSelect, powerDown_n;
    logic [1:0] modeSelect;
    logic selftestEnable, serialOutP, serialOutN, pllEnable, driveLevel;
    logic legacyMode, filterActive;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic run, lowSeen;
    logic [7:0] halfPeriod;
    logic [26:0] riseWord, fallWord;
    logic [29:0] hist;
    logic [31:0] rd, f0;
    logic [1:0] rs;
    logic [26:0] sw;
    logic swInv;
    wire [2:0] modeOut = {filterActive, legacyMode, driveLevel};
    int n_fail = 0;
    int samples_checked = 0;

    spc_top DUT (.*);
    spc_pixel_source u_src (.*);

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        hist <= {hist[28:0], serialOutP};
        if (rst_n && powerDown_n && !pixelReady) lowSeen <= 1'b1;
    end

    // ------------------------------------------------------------
    // Bus and stimulus tasks
    // ------------------------------------------------------------
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] r);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        @(posedge mclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic pixels(input int n);
        @(posedge mclk);
        run <= 1'b1;
        repeat (n * 2 * halfPeriod) @(posedge mclk);
        run <= 1'b0;
    endtask

    // Frame: start 1, payload LSB first, invert flag, stop 0
    task automatic exp_frame(input logic [26:0] w, input logic inv);
        logic [29:0] e;
        int k;
        e = {1'b1, 27'h0, inv, 1'b0};
        for (k = 0; k < 27; k++) e[28 - k] = w[k];
        k = 0;
        while (hist !== e && k < 400) begin
            @(posedge mclk);
            k++;
        end
        `CHK("frame", e, hist)
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        {powerDown_n, strobeEdgeSelect, driveLevelSelect} = 3'b110;
        modeSelect = 2'b11;
        selftestEnable = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
        {s_axi_arvalid, s_axi_rready} = 2'b00;
        s_axi_wstrb = 4'hf;
        {run, lowSeen} = 2'b00;
        halfPeriod = 8'd20;
        // Controls equal in both words so they never toggle mid-run
        riseWord = 27'h1a5c3f0;
        fallWord = 27'h13c1e87;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        axr(spc_pkg::ADDR_CTRL, rd, rs);
        `CHK("ctrl reset", {25'h0, spc_pkg::CTRL_RESET}, rd)
        axr(spc_pkg::ADDR_STATUS, rd, rs);
        `CHK("status", 32'h0000000f, rd)
        axr(spc_pkg::ADDR_FRAMES, f0, rs);
        fork
            pixels(1);
            exp_frame(riseWord, 1'b0);
        join
        axr(spc_pkg::ADDR_FRAMES, rd, rs);
        `CHK("frames", f0 + 32'h1, rd)
        strobeEdgeSelect <= 1'b0;
        fork
            pixels(1);
            exp_frame(fallWord, 1'b0);
        join
        // Fast source overruns the serializer; drops are flagged
        strobeEdgeSelect <= 1'b1;
        halfPeriod <= 8'd4;
        pixels(40);
        `CHK("full seen", 1'b1, lowSeen)
        axr(spc_pkg::ADDR_STATUS, rd, rs);
        `CHK("drop set", 1'b1, rd[spc_pkg::STAT_DROP])
        axw(spc_pkg::ADDR_STATUS, 32'h00000020, rs);
        // At most five queued frames (four in the FIFO, one in capture) remain to drain
        repeat (200) @(posedge mclk);
        axr(spc_pkg::ADDR_STATUS, rd, rs);
        `CHK("drained", 2'b01, {rd[spc_pkg::STAT_DROP], pixelReady})
        halfPeriod <= 8'd20;
        // Register overrides, then power-down clears them
        axw(spc_pkg::ADDR_CTRL, 32'h0000006f, rs);
        `CHK("wr resp", spc_pkg::RESP_OKAY, rs)
        axr(spc_pkg::ADDR_CTRL, rd, rs);
        `CHK("ctrl rw", 32'h0000006f, rd)
        `CHK("override", 3'b101, modeOut)
        powerDown_n <= 1'b0;
        repeat (3) @(posedge mclk);
        `CHK("parked", 3'b110, {serialOutP, serialOutN, pllEnable})
        powerDown_n <= 1'b1;
        axr(spc_pkg::ADDR_CTRL, rd, rs);
        `CHK("ctrl cleared", 32'h0, rd)
        `CHK("drive pin", 1'b0, driveLevel)
        // Filter on, scrambler fresh from power-down: a one-pixel enable
        // pulse is held back, the word goes out scrambled and balanced
        modeSelect <= spc_pkg::CFG_FILT_ON;
        sw = (riseWord & 27'h6ffffff) ^
            {spc_pkg::SCR_SEED[10:0], spc_pkg::SCR_SEED};
        swInv = ($countones(sw) <= spc_pkg::BAL_HALF);
        fork
            pixels(1);
            exp_frame(swInv ? ~sw : sw, swInv);
        join
        for (int m = 0; m < 4; m++) begin
            modeSelect <= m[1:0];
            driveLevelSelect <= m[0];
            repeat (3) @(posedge mclk);
            `CHK("mode", {m == 1, m[1:0]}, modeOut)
        end
        selftestEnable <= 1'b1;
        axr(spc_pkg::ADDR_FRAMES, f0, rs);
        repeat (100) @(posedge mclk);
        axr(spc_pkg::ADDR_FRAMES, rd, rs);
        `CHK("test frames", 1'b1, rd - f0 >= 32'd3)
        selftestEnable <= 1'b0;
        // Let a frame in flight finish before counting again
        repeat (40) @(posedge mclk);
        axr(spc_pkg::ADDR_FRAMES, f0, rs);
        repeat (100) @(posedge mclk);
        axr(spc_pkg::ADDR_FRAMES, rd, rs);
        `CHK("quiet link", f0, rd)
        axr(8'h10, rd, rs);
        `CHK("unmapped rd", {spc_pkg::RESP_SLVERR, 32'h0}, {rs, rd})
        axw(8'h10, 32'h00000001, rs);
        `CHK("unmapped wr", spc_pkg::RESP_SLVERR, rs)
        wrap_up();
    end

    initial begin
        repeat (40000) @(posedge mclk);
        n_fail++;
        wrap_up();
    end
endmodule // serializer_parallel_input_capture_tb_top
